//--- txb_defs.svh
// field positions, codes and limits of the transmit buffer command words
`ifndef TXB_DEFS_SVH
`define TXB_DEFS_SVH
`define TXB_WORD_W      32
`define TXB_FIFO_DEPTH  8
`define TXB_A_SIZE_MSB  10
`define TXB_A_SIZE_LSB  0
`define TXB_A_LS_BIT    12
`define TXB_A_FS_BIT    13
`define TXB_A_OFF_MSB   20
`define TXB_A_OFF_LSB   16
`define TXB_A_ALN_MSB   25
`define TXB_A_ALN_LSB   24
`define TXB_B_LEN_MSB   10
`define TXB_B_LEN_LSB   0
`define TXB_B_NOPAD_BIT 12
`define TXB_B_NOCRC_BIT 13
`define TXB_B_TAG_MSB   31
`define TXB_B_TAG_LSB   16
`define TXB_ALN_4       2'h0
`define TXB_ALN_16      2'h1
`define TXB_ALN_32      2'h2
`define TXB_MIN_MID     11'h004
`define TXB_MAX_FRAGS   7'h56
`endif

//--- txb_pkg.sv
// types and shared arithmetic of the transmit buffer command parser
package txb_pkg;
`include "txb_defs.svh"

	typedef enum logic [2:0] {ST_CMDA, ST_CMDB, ST_SKIP, ST_DATA, ST_TAIL} txb_dev_state_type;
	typedef enum logic [1:0] {HS_IDLE, HS_CMDA, HS_CMDB, HS_DATA} txb_host_state_type;

	// alignment in bytes; the reserved code is treated as 4-byte
	function automatic logic [12:0] txbAlignBytes(input logic [1:0] sel);
		unique case (sel)
			`TXB_ALN_16: txbAlignBytes = 13'h0010;
			`TXB_ALN_32: txbAlignBytes = 13'h0020;
			default:     txbAlignBytes = 13'h0004;
		endcase
	endfunction

	// dwords in the buffer after the command words: offset, payload and filler
	function automatic logic [10:0] txbTotalDw(input logic [4:0] off, input logic [10:0] size,
		input logic [1:0] aln);
		logic [12:0] endByte;
		logic [12:0] mask;
		endByte = {8'h00, off} + {2'h0, size} + txbAlignBytes(aln) - 13'h0001;
		mask    = txbAlignBytes(aln) - 13'h0001;
		endByte = endByte & ~mask;
		txbTotalDw = endByte[12:2];
	endfunction

	// dwords that carry at least one payload byte
	function automatic logic [10:0] txbDataDw(input logic [1:0] lane, input logic [10:0] size);
		logic [12:0] sum;
		sum = {11'h000, lane} + {2'h0, size} + 13'h0003;
		// an empty buffer carries no payload word, whatever its start lane
		txbDataDw = (size == 11'h000) ? 11'h000 : sum[12:2];
	endfunction
endpackage

//--- txb_link_if.sv
// word link from the host end into the device transmit data FIFO
`timescale 1ns/1ps
interface txb_link_if;
	logic [31:0] word;
	logic        wordValid;
	logic        wordReady;

	modport hostEnd (output word, output wordValid, input wordReady);
	modport devEnd  (input word, input wordValid, output wordReady);
endinterface

//--- txb_fifo.sv
// small synchronous word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module txb_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// fill side
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	// drain side
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] memQ [DEPTH];
	logic [AW-1:0]    wrPtrQ;
	logic [AW-1:0]    rdPtrQ;
	logic [AW:0]      countQ;
	logic             push;
	logic             pop;

	// honest flags straight from the occupancy count
	// depth compared at the count's full width; an address-wide cast of the depth would wrap to zero
	assign inReady  = (countQ != (AW+1)'(DEPTH));
	assign outValid = (countQ != '0);
	assign outData  = memQ[rdPtrQ];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// storage has no reset; only pointers matter
	always_ff @(posedge core_clk) begin
		if (push) begin
			memQ[wrPtrQ] <= inData;
		end
	end

	// pointers wrap naturally at a power-of-two depth
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wrPtrQ <= '0;
			rdPtrQ <= '0;
			countQ <= '0;
		end else begin
			if (push) wrPtrQ <= wrPtrQ + AW'(1);
			if (pop) rdPtrQ <= rdPtrQ + AW'(1);
			countQ <= countQ + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // txb_fifo

//--- txb_dev_end.sv
// device end: parses command/data words and forwards valid payload bytes
// What the document requires of the transmit path
// R1: command A bits 10:0 give payload bytes
// R2: derive and discard trailing filler dwords
// R3: sum buffer sizes, flag mismatch with length
// R4: copy packet tag into status word
// R5: command B bit 13 suppresses CRC
// R6: bit 12 clear pads short frames
// R7: padding off still forces CRC on
// R8: command B bits 10:0 give packet length
// R9: host writes reserved bits as zero
// R10: payload starts after command A, plus command B on a first segment
// R11: offset low bits pick first byte lane
// R12: offset bits 4:2 skip whole dwords
// R13: unused trailing bytes never reach MAC
// R14: end filler to 4/16/32 bytes, removed
// R15: middle buffers hold at least four bytes
// R16: MAC side takes packets store-and-forward
// R17: host keeps packet MAC space within 2036
// R18: only payload-bearing dwords reach MAC FIFO
// R19: up to 86 buffers is always safe
// R20: command A bit 13 marks first segment
// R21: command A bit 12 marks last segment
`timescale 1ns/1ps
`include "txb_defs.svh"
module txb_dev_end
	import txb_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// host word link
	txb_link_if.devEnd       link,
	// mac_tx_fifo_layer write side
	output logic [31:0]      macData,
	output logic [3:0]       macByteEn,
	output logic             macValid,
	output logic             macLast,
	output logic             macAddCrc,
	output logic             macAddPad,
	input  wire logic        macReady,
	// per-packet status
	output logic             statusValid,
	output logic [15:0]      statusTag,
	output logic             statusLenErr,
	// sticky tx_error_flag
	output logic             txErrorFlag,
	input  wire logic        txErrorClear
);
	logic [31:0]       fifoWord;
	logic              fifoValid;
	logic              fifoPop;
	txb_dev_state_type stateQ;
	txb_dev_state_type stateD;
	logic [31:0]       cmdAQ;
	logic [31:0]       hdrWord;
	logic [10:0]       cntQ;
	logic [10:0]       cntD;
	logic              firstWordQ;
	logic [11:0]       sumQ;
	logic [10:0]       pktLenQ;
	logic              take;
	logic              outFree;
	logic              bufDone;
	logic [4:0]        offs;
	logic [10:0]       bufSize;
	logic [10:0]       skipDw;
	logic [10:0]       dataDw;
	logic [10:0]       tailDw;
	logic [1:0]        endLane;
	logic              pktEnd;
	logic              lenMismatch;

	// eight-word buffer between the link and the parser; its ready is the link back-pressure
	txb_fifo #(
		.WIDTH(`TXB_WORD_W),
		.DEPTH(`TXB_FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.sys_rst (sys_rst),
		.inData  (link.word),
		.inValid (link.wordValid),
		.inReady (link.wordReady),
		.outData (fifoWord),
		.outValid(fifoValid),
		.outReady(fifoPop)
	);

	// byte-enable mask for lanes lo..hi
	function automatic logic [3:0] laneMask(input logic [1:0] lo, input logic [1:0] hi);
		logic [3:0] m;
		m = 4'h0;
		for (int i = 0; i < 4; i++) begin
			m[i] = (2'(i) >= lo) && (2'(i) <= hi);
		end
		laneMask = m;
	endfunction

	// command A is still on the FIFO head while in the first state
	assign hdrWord = (stateQ == ST_CMDA) ? fifoWord : cmdAQ;
	assign offs    = hdrWord[`TXB_A_OFF_MSB:`TXB_A_OFF_LSB];
	assign bufSize = hdrWord[`TXB_A_SIZE_MSB:`TXB_A_SIZE_LSB]; // R1
	assign skipDw  = {8'h00, offs[4:2]}; // R12
	assign dataDw  = txbDataDw(offs[1:0], bufSize);
	// whole filler dwords left over after the payload
	assign tailDw  = txbTotalDw(offs, bufSize, hdrWord[`TXB_A_ALN_MSB:`TXB_A_ALN_LSB]) - skipDw - dataDw; // R2 R14
	assign endLane = 2'(offs[1:0] + bufSize[1:0] - 2'h1);

	// a data word only moves when the output register is free; command B waits too,
	// so the per-packet controls cannot change under a pending last word
	assign outFree = !macValid || macReady;
	assign take    = fifoValid && (((stateQ != ST_DATA) && (stateQ != ST_CMDB)) || outFree); // R5 R6
	assign fifoPop = take;

	// phase sequencing: header, skip, data, filler; empty phases are jumped over
	always_comb begin
		stateD  = stateQ;
		cntD    = cntQ;
		bufDone = 1'b0;
		if (take) begin
			unique case (stateQ)
				ST_CMDA, ST_CMDB: begin
					if (stateQ == ST_CMDA && fifoWord[`TXB_A_FS_BIT]) begin
						stateD = ST_CMDB; // R20
					end else if (skipDw != 11'h000) begin
						stateD = ST_SKIP; // R10
						cntD   = skipDw;
					end else if (dataDw != 11'h000) begin
						stateD = ST_DATA;
						cntD   = dataDw;
					end else if (tailDw != 11'h000) begin
						stateD = ST_TAIL;
						cntD   = tailDw;
					end else begin
						stateD  = ST_CMDA;
						bufDone = 1'b1;
					end
				end
				ST_SKIP: begin
					cntD = cntQ - 11'h001;
					if (cntQ == 11'h001) begin
						if (dataDw != 11'h000) begin
							stateD = ST_DATA;
							cntD   = dataDw;
						end else if (tailDw != 11'h000) begin
							stateD = ST_TAIL;
							cntD   = tailDw;
						end else begin
							stateD  = ST_CMDA;
							bufDone = 1'b1;
						end
					end
				end
				ST_DATA: begin
					cntD = cntQ - 11'h001;
					if (cntQ == 11'h001) begin
						if (tailDw != 11'h000) begin
							stateD = ST_TAIL;
							cntD   = tailDw;
						end else begin
							stateD  = ST_CMDA;
							bufDone = 1'b1;
						end
					end
				end
				ST_TAIL: begin
					cntD = cntQ - 11'h001;
					if (cntQ == 11'h001) begin
						stateD  = ST_CMDA;
						bufDone = 1'b1;
					end
				end
			endcase
		end
	end

	// state, counter and stored command A
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stateQ <= ST_CMDA;
			cntQ   <= 11'h000;
			cmdAQ  <= 32'h0000_0000;
		end else begin
			stateQ <= stateD;
			cntQ   <= cntD;
			if (take && stateQ == ST_CMDA) cmdAQ <= fifoWord;
		end
	end

	// first payload word of a buffer gets the start-lane mask
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			firstWordQ <= 1'b1;
		end else if (take) begin
			firstWordQ <= (stateD != ST_DATA) || (stateQ != ST_DATA);
		end
	end

	// running size sum restarts on a first segment
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sumQ <= 12'h000;
		end else if (take && stateQ == ST_CMDA) begin
			if (fifoWord[`TXB_A_FS_BIT]) sumQ <= {1'b0, bufSize}; // R3
			else sumQ <= sumQ + {1'b0, bufSize}; // R3
		end
	end

	// command B controls held for the whole packet
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pktLenQ   <= 11'h000;
			statusTag <= 16'h0000;
			macAddCrc <= 1'b1;
			macAddPad <= 1'b1;
		end else if (take && stateQ == ST_CMDB) begin
			pktLenQ   <= fifoWord[`TXB_B_LEN_MSB:`TXB_B_LEN_LSB]; // R8
			statusTag <= fifoWord[`TXB_B_TAG_MSB:`TXB_B_TAG_LSB]; // R4
			// padding suppressed forces the checksum back on
			macAddCrc <= !fifoWord[`TXB_B_NOCRC_BIT] || fifoWord[`TXB_B_NOPAD_BIT]; // R5 R7
			macAddPad <= !fifoWord[`TXB_B_NOPAD_BIT]; // R6
		end
	end

	// only payload dwords reach the MAC, with unused lanes masked off
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			macData   <= 32'h0000_0000;
			macByteEn <= 4'h0;
			macValid  <= 1'b0;
			macLast   <= 1'b0;
		end else if (outFree) begin
			macValid <= take && (stateQ == ST_DATA); // R18
			if (take && stateQ == ST_DATA) begin
				macData   <= fifoWord;
				macByteEn <= laneMask(firstWordQ ? offs[1:0] : 2'h0, // R11
					(cntQ == 11'h001) ? endLane : 2'h3); // R13
				// packet closes on the last payload word of a last segment
				macLast   <= (cntQ == 11'h001) && cmdAQ[`TXB_A_LS_BIT]; // R16 R21
			end
		end
	end

	// length check at the close of the last segment
	assign pktEnd      = bufDone && hdrWord[`TXB_A_LS_BIT]; // R21
	assign lenMismatch = sumQ[10:0] != pktLenQ || sumQ[11]; // R3 R8

	// one status pulse per packet
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			statusValid  <= 1'b0;
			statusLenErr <= 1'b0;
		end else begin
			statusValid <= pktEnd;
			if (pktEnd) statusLenErr <= lenMismatch;
		end
	end

	// sticky error; a new mismatch wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			txErrorFlag <= 1'b0;
		end else if (pktEnd && lenMismatch) begin
			txErrorFlag <= 1'b1; // R3
		end else if (txErrorClear) begin
			txErrorFlag <= 1'b0;
		end
	end
endmodule // txb_dev_end

//--- txb_host_end.sv
// host end: builds command words and streams buffer words onto the link
`timescale 1ns/1ps
`include "txb_defs.svh"
module txb_host_end
	import txb_pkg::*;
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// buffer command request
	input  wire logic        cmdValid,
	output logic             cmdReady,
	input  wire logic        cmdFirst,
	input  wire logic        cmdLast,
	input  wire logic [4:0]  cmdOffset,
	input  wire logic [1:0]  cmdAlign,
	input  wire logic [10:0] cmdSize,
	input  wire logic [10:0] cmdPktLen,
	input  wire logic [15:0] cmdTag,
	input  wire logic        cmdNoCrc,
	input  wire logic        cmdNoPad,
	// raw buffer words including offset and filler
	input  wire logic [31:0] dataWord,
	input  wire logic        dataValid,
	output logic             dataReady,
	// checks on the request
	output logic             cmdRefused,
	output logic             fragOver,
	// word link
	txb_link_if.hostEnd      link
);
	txb_host_state_type stateQ;
	logic [31:0]        cmdAQ;
	logic [31:0]        cmdBQ;
	logic [10:0]        cntQ;
	logic [6:0]         fragQ;
	logic               linkFree;
	logic               accept;
	logic               tooShort;

	assign linkFree  = !link.wordValid || link.wordReady;
	assign dataReady = (stateQ == HS_DATA) && linkFree;
	assign accept    = cmdValid && cmdReady;
	// a middle segment below four bytes is never sent
	assign tooShort  = !cmdFirst && !cmdLast && (cmdSize < `TXB_MIN_MID); // R15

	// command capture; reserved bits built as zero
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cmdAQ <= 32'h0000_0000;
			cmdBQ <= 32'h0000_0000;
		end else if (accept && !tooShort) begin
			cmdAQ <= {6'h00, cmdAlign, 3'h0, cmdOffset, 2'h0, cmdFirst, cmdLast, 1'b0, cmdSize}; // R9 R20 R21
			cmdBQ <= {cmdTag, 2'h0, cmdNoCrc, cmdNoPad, 1'b0, cmdPktLen}; // R9
		end
	end

	// sequencing of command A, command B on a first segment, then the buffer words
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stateQ   <= HS_IDLE;
			cmdReady <= 1'b1;
			cntQ     <= 11'h000;
		end else begin
			unique case (stateQ)
				HS_IDLE: if (accept && !tooShort) begin
					stateQ   <= HS_CMDA;
					cmdReady <= 1'b0;
					cntQ     <= txbTotalDw(cmdOffset, cmdSize, cmdAlign); // R14
				end
				HS_CMDA: if (linkFree) begin
					stateQ <= cmdAQ[`TXB_A_FS_BIT] ? HS_CMDB : (cntQ != 11'h000 ? HS_DATA : HS_IDLE);
					cmdReady <= !cmdAQ[`TXB_A_FS_BIT] && cntQ == 11'h000;
				end
				HS_CMDB: if (linkFree) begin
					stateQ   <= (cntQ != 11'h000) ? HS_DATA : HS_IDLE;
					cmdReady <= cntQ == 11'h000;
				end
				HS_DATA: if (dataValid && linkFree) begin
					cntQ <= cntQ - 11'h001;
					if (cntQ == 11'h001) begin
						stateQ   <= HS_IDLE;
						cmdReady <= 1'b1;
					end
				end
			endcase
		end
	end

	// link word register; held until the device takes it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			link.word      <= 32'h0000_0000;
			link.wordValid <= 1'b0;
		end else if (linkFree) begin
			link.wordValid <= (stateQ == HS_CMDA) || (stateQ == HS_CMDB) || (stateQ == HS_DATA && dataValid);
			unique case (stateQ)
				HS_CMDA: link.word <= cmdAQ;
				HS_CMDB: link.word <= cmdBQ;
				HS_DATA: link.word <= dataWord;
				default: link.word <= link.word;
			endcase
		end
	end

	// refusal pulse and fragment count; beyond the safe count the MAC space may overflow
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cmdRefused <= 1'b0;
			fragQ      <= 7'h00;
			fragOver   <= 1'b0;
		end else begin
			cmdRefused <= accept && tooShort;
			if (accept && !tooShort) begin
				fragQ    <= cmdFirst ? 7'h01 : fragQ + {6'h00, fragQ != 7'h7F};
				fragOver <= cmdFirst ? 1'b0 : (fragOver || fragQ >= `TXB_MAX_FRAGS); // R17 R19
			end
		end
	end
endmodule // txb_host_end

//--- txb_link_monitor.sv
// link checker: handshake and buffer framing between host end and device end
`timescale 1ns/1ps
module txb_link_monitor (
	// clock and reset
	input wire logic        core_clk,
	input wire logic        sys_rst,
	// word link
	input wire logic [31:0] word,
	input wire logic        wordValid,
	input wire logic        wordReady
);
	logic        take;
	logic [12:0] alnB;
	logic [12:0] endB;
	logic [1:0]  phase_q;
	logic [10:0] rem_q;
	logic        open_q;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// buffer length in dwords, valid only when the word is a command A
	assign take = wordValid && wordReady;
	assign alnB = (word[25:24] == 2'h1) ? 13'h0010 : ((word[25:24] == 2'h2) ? 13'h0020 : 13'h0004);
	assign endB = ({8'h00, word[20:16]} + {2'h0, word[10:0]} + alnB - 13'h0001) & ~(alnB - 13'h0001);
	// phase 0 waits for command A, 1 for command B, 2 counts buffer words
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase_q <= 2'h0;
			rem_q   <= 11'h000;
			open_q  <= 1'b0;
		end else if (take && phase_q == 2'h0) begin
			rem_q   <= endB[12:2];
			open_q  <= !word[12];
			phase_q <= word[13] ? 2'h1 : ((endB[12:2] == 11'h000) ? 2'h0 : 2'h2);
		end else if (take && phase_q == 2'h1) begin
			phase_q <= (rem_q == 11'h000) ? 2'h0 : 2'h2;
		end else if (take) begin
			rem_q   <= rem_q - 11'h001;
			phase_q <= (rem_q == 11'h001) ? 2'h0 : 2'h2;
		end
	end
	a_link_held: assert property (wordValid && !wordReady |=> wordValid && $stable(word))
		else $error("link word changed before taken");
	a_ready_reset: assert property ($past(sys_rst) |-> wordReady && !wordValid)
		else $error("link not idle after reset");
	a_ready_falls: assert property ($fell(wordReady) |-> $past(take))
		else $error("link ready fell without a write");
	a_ready_returns: assert property (!wordReady |-> ##[1:300] wordReady)
		else $error("link stalled too long");
	a_cmdb_reserved: assert property (take && phase_q == 2'h1 |-> word[15:14] == 2'h0 && !word[11])
		else $error("reserved command B bits set");
	a_mid_size: assert property (take && phase_q == 2'h0 && !word[13] && !word[12] |-> word[10:0] >= 11'h004)
		else $error("short middle buffer sent");
	a_segment_order: assert property (take && phase_q == 2'h0 |-> word[13] == !open_q)
		else $error("segment flags out of order");
	a_align_code: assert property (take && phase_q == 2'h0 |-> word[25:24] != 2'h3)
		else $error("reserved alignment code sent");
endmodule // txb_link_monitor

//--- test_tx_buffer_command_parser.sv
// self-checking bench: host end and device end joined over the word link
`timescale 1ns/1ps
module test_tx_buffer_command_parser;
	logic        core_clk, sys_rst, cmdValid, cmdFirst, cmdLast, cmdNoCrc, cmdNoPad, dataValid;
	logic        macReady, txErrorClear, cmdReady, dataReady, cmdRefused, fragOver;
	logic        macValid, macLast, macAddCrc, macAddPad, statusValid, statusLenErr, txErrorFlag;
	logic [4:0]  cmdOffset;
	logic [1:0]  cmdAlign;
	logic [10:0] cmdSize, cmdPktLen;
	logic [15:0] cmdTag, statusTag;
	logic [31:0] dataWord, macData, em, es;
	logic [3:0]  macByteEn;
	logic [7:0]  expB[$];
	logic [31:0] expM[$], expS[$];
	int          n_mismatch, n_compared, k, gw, stall;
	int          seed = 32'h6B24;
	txb_link_if link ();
	txb_host_end u_txb_host_end (.core_clk(core_clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdFirst(cmdFirst), .cmdLast(cmdLast), .cmdOffset(cmdOffset), .cmdAlign(cmdAlign), .cmdSize(cmdSize),
		.cmdPktLen(cmdPktLen), .cmdTag(cmdTag), .cmdNoCrc(cmdNoCrc), .cmdNoPad(cmdNoPad), .dataWord(dataWord),
		.dataValid(dataValid), .dataReady(dataReady), .cmdRefused(cmdRefused), .fragOver(fragOver), .link(link));
	txb_dev_end u_txb_dev_end (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .macData(macData),
		.macByteEn(macByteEn), .macValid(macValid), .macLast(macLast), .macAddCrc(macAddCrc), .macAddPad(macAddPad),
		.macReady(macReady), .statusValid(statusValid), .statusTag(statusTag), .statusLenErr(statusLenErr),
		.txErrorFlag(txErrorFlag), .txErrorClear(txErrorClear));
	txb_link_monitor u_txb_link_monitor (.core_clk(core_clk), .sys_rst(sys_rst), .word(link.word),
		.wordValid(link.wordValid), .wordReady(link.wordReady));
	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// bounded wait for cmdReady (0) or dataReady (1) sampled high at an edge
	task automatic await(input int sel);
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (!((sel == 0) ? cmdReady === 1'b1 : dataReady === 1'b1) && k < 500);
		if (k >= 500) begin
			n_mismatch++;
			end_sim;
		end
	endtask
	function automatic int al(input logic [1:0] a);
		return (a == 2'h1) ? 16 : ((a == 2'h2) ? 32 : 4);
	endfunction
	// one buffer: offset and filler bytes are random junk, payload bytes are expected at the MAC
	task automatic send_buf(input logic fs, ls, input logic [4:0] off, input logic [1:0] aln,
		input logic [10:0] sz, len, input logic [15:0] tag, input logic nc, np);
		int         tot;
		int         p;
		logic [7:0] b;
		logic       r;
		tot = (off + sz + al(aln) - 1) / al(aln) * al(aln) / 4;
		{cmdFirst, cmdLast, cmdOffset, cmdAlign, cmdSize, cmdPktLen, cmdTag, cmdNoCrc, cmdNoPad} =
			{fs, ls, off, aln, sz, len, tag, nc, np};
		cmdValid = 1'b1;
		await(0);
		#1 cmdValid = 1'b0;
		if (!fs && !ls && sz < 11'h004) begin
			r = 1'b0;
			repeat (2) begin
				@(posedge core_clk);
				r = r | cmdRefused;
			end
			#1;
			check(r, 1'b1);
			return;
		end
		for (int w = 0; w < tot; w++) begin
			for (int i = 0; i < 4; i++) begin
				b = $random(seed);
				p = w * 4 + i;
				if (p >= off && p < off + sz) expB.push_back(b);
				dataWord[8*i +: 8] = b;
			end
			dataValid = 1'b1;
			await(1);
			#1;
		end
		dataValid = 1'b0;
	endtask
	// packet of nb buffers; adj skews the declared length, fix forces every size
	task automatic send_pkt(input int nb, adj, input logic [1:0] aln, input logic nc, np, input int fix);
		int          s[128];
		int          o[128];
		int          sum;
		int          words;
		logic [15:0] tag;
		tag = $random(seed);
		sum = 0;
		words = 0;
		for (int i = 0; i < nb; i++) begin
			o[i] = {$random(seed)} % 32;
			s[i] = (fix > 0) ? fix : ((i == 0 || i == nb - 1) ? 1 + {$random(seed)} % 90 : 4 + {$random(seed)} % 17);
			sum += s[i];
			words += ((o[i] % 4) + s[i] + 3) / 4;
		end
		expS.push_back({15'h0000, adj != 0, tag});
		expM.push_back({18'h00000, !nc || np, !np, 12'(words)});
		for (int i = 0; i < nb; i++) send_buf(i == 0, i == nb - 1, o[i], aln, s[i], 11'(sum + adj), tag, nc, np);
	endtask
	task automatic drain;
		k = 0;
		while ((expS.size() > 0 || expM.size() > 0) && k < 3000) begin
			@(posedge core_clk);
			k++;
		end
		if (k >= 3000) begin
			n_mismatch++;
			end_sim;
		end
		@(posedge core_clk);
		#1 check(32'(expB.size()), 32'h0);
	endtask
	// MAC sink stalls at random, or fully while stall is set
	always @(posedge core_clk) begin
		#1 macReady = (stall == 0) ? 1'($random(seed)) : 1'b0;
	end
	// collector: payload bytes in order, per-packet controls and status
	always @(posedge core_clk) begin
		if (!sys_rst && macValid === 1'b1 && macReady === 1'b1) begin
			gw++;
			for (int i = 0; i < 4; i++) begin
				if (macByteEn[i] === 1'b1) check(macData[8*i +: 8], expB.pop_front());
			end
			if (macLast === 1'b1) begin
				em = expM.pop_front();
				check({macAddCrc, macAddPad, 12'(gw)}, em[13:0]);
				gw = 0;
			end
		end
		if (!sys_rst && statusValid === 1'b1) begin
			es = expS.pop_front();
			check({statusLenErr, statusTag}, es[16:0]);
			if (es[16]) check(txErrorFlag, 1'b1);
		end
	end
	// bound on the whole run
	initial begin
		repeat (100000) @(posedge core_clk);
		n_mismatch++;
		end_sim;
	end
	initial begin
		{cmdValid, cmdFirst, cmdLast, cmdOffset, cmdAlign, cmdSize, cmdPktLen, cmdTag, cmdNoCrc, cmdNoPad} = '0;
		{dataWord, dataValid, macReady, txErrorClear, stall, gw} = '0;
		sys_rst = 1'b1;
		repeat (20) @(posedge core_clk);
		#1 sys_rst = 1'b0;
		for (int i = 0; i < 24; i++) send_pkt(1 + (i / 4) % 3, 0, 2'(i % 3), i[0], i[1], 0);
		drain();
		check(fragOver, 1'b0);
		$display("random packets done");
		send_pkt(2, 1, 2'h1, 1'b0, 1'b0, 0);
		drain();
		check(txErrorFlag, 1'b1);
		txErrorClear = 1'b1;
		@(posedge core_clk);
		#1 txErrorClear = 1'b0;
		check(txErrorFlag, 1'b0);
		$display("length mismatch done");
		expS.push_back(32'h000000A5);
		expM.push_back(32'h00003004);
		send_buf(1'b1, 1'b0, 5'h00, 2'h0, 11'h008, 11'h00D, 16'h00A5, 1'b0, 1'b0);
		send_buf(1'b0, 1'b0, 5'h00, 2'h0, 11'h003, 11'h00D, 16'h00A5, 1'b0, 1'b0);
		send_buf(1'b0, 1'b1, 5'h00, 2'h0, 11'h005, 11'h00D, 16'h00A5, 1'b0, 1'b0);
		drain();
		$display("short middle buffer done");
		stall = 1;
		fork
			send_pkt(1, 0, 2'h2, 1'b1, 1'b1, 80);
			begin
				repeat (40) @(posedge core_clk);
				check(link.wordReady, 1'b0);
				stall = 0;
			end
		join
		drain();
		$display("full link done");
		send_pkt(87, 0, 2'h0, 1'b0, 1'b0, 4);
		check(fragOver, 1'b1);
		drain();
		$display("fragmented packet done");
		end_sim();
	end
endmodule // test_tx_buffer_command_parser
